// file: rtl/vlan_hash_pkg.sv
// Shared constants and carrier types for the VLAN filter and receive hash block.
package vlan_hash_pkg;

    // Register byte addresses.
    localparam logic [15:0] VLAN_FILTER_BASE = 16'h5600;
    localparam logic [15:0] VLAN_FILTER_LAST = 16'h57FC;
    localparam logic [15:0] MULTI_QUEUE_COMMAND_ADDR = 16'h5818;
    localparam logic [15:0] HASH_INTERRUPT_MASK_ADDR = 16'h5864;
    localparam logic [15:0] HASH_INTERRUPT_REQUEST_ADDR = 16'h5868;
    localparam logic [15:0] EVENT_STATUS_ADDR = 16'h5870;
    localparam logic [15:0] EVENT_MASK_ADDR = 16'h5874;
    localparam logic [15:0] FILTER_CONTROL_ADDR = 16'h5878;

    // Filter array geometry and lookup index fields.
    localparam int VLAN_WORDS = 128;
    localparam int ROW_WIDTH = 7;
    localparam int ROW_MSB = 11;
    localparam int ROW_LSB = 5;
    localparam int COL_MSB = 4;
    localparam int ADDR_ROW_LSB = 2;

    // Multi queue command fields.
    localparam int QUEUE_ENABLE_LSB = 0;
    localparam logic [1:0] QUEUE_MODE_OFF = 2'h0;
    localparam logic [1:0] QUEUE_MODE_HASH = 2'h1;
    localparam int HASH_INT_ENABLE_BIT = 2;
    localparam int FIELD_ENABLE_LSB = 16;
    localparam int FIELD_ENABLE_WIDTH = 5;
    localparam int FIELD_IPV6EX = 3;
    localparam int FIELD_IPV6 = 4;
    localparam logic [31:0] MULTI_QUEUE_COMMAND_RESET = 32'h0000_0000;
    localparam logic [31:0] HASH_INTERRUPT_MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] HASH_INTERRUPT_REQUEST_RESET = 32'h0000_0000;

    // Reported hash types.
    localparam logic [3:0] HASH_TYPE_NONE = 4'h0;
    localparam logic [3:0] HASH_TYPE_IPV6EX = 4'h4;
    localparam logic [3:0] HASH_TYPE_IPV6 = 4'h5;

    // Event status layout, shared by the event mask.
    localparam int EVENT_WIDTH = 3;
    localparam int EVENT_VLAN_DROP = 0;
    localparam int EVENT_RX_INTERRUPT = 1;
    localparam int EVENT_BUS_ERROR = 2;
    localparam logic [2:0] EVENT_RESET = 3'h0;
    localparam int FILTER_ENABLE_BIT = 0;
    localparam logic FILTER_CONTROL_RESET = 1'h0;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_type;

    typedef struct packed {
        logic valid;
        logic [11:0] vlan_id;
    } lookup_req_type;

    typedef struct packed {
        logic done;
        logic pass;
    } lookup_rsp_type;

    typedef struct packed {
        logic rx_packet;
        logic [31:0] posted;
        logic [31:0] timer_expired;
    } rx_event_type;

    typedef struct packed {
        logic valid;
        logic is_ipv6;
        logic has_ext_option;
    } hash_class_type;

    typedef struct packed {
        logic queue_steering_enable;
        logic [4:0] field_enable;
        logic rx_int_pulse;
        logic hash_type_valid;
        logic [3:0] hash_type;
    } steer_type;

endpackage : vlan_hash_pkg

// file: rtl/filter_word_array.sv
// Storage for the 128-word VLAN filter bit array with two read ports.
module filter_word_array (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [6:0] wr_row,
    input wire logic [31:0] wr_data,
    input wire logic [6:0] bus_row,
    output logic [31:0] bus_data,
    input wire logic [6:0] look_row,
    output logic [31:0] look_data
);
    import vlan_hash_pkg::*;

    // No reset: contents stay undefined until software fills them.
    logic [31:0] words [VLAN_WORDS];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            words[wr_row] <= wr_data;
        end
    end

    assign bus_data = words[bus_row];
    assign look_data = words[look_row];

endmodule : filter_word_array

// file: rtl/vlan_filter_and_rx_hash_ctrl.sv
// APB register bank for VLAN filtering and receive hash steering control.
// Functional notes
// - 4096 filter bits held as 128 words of 32 bits.
// - VLAN tag lookup tests one array bit, as multicast hashing does.
// - Index bits 11:5 pick the row, bits 4:0 the bit.
// - Queue mode 00 disables queues, 01 hash steering when packet checksum disable is set, others reserved.
// - Bit 2 set gates receive interrupts by mask; clear, every packet.
// - Bits 20:16 select hash inputs; bits 31:21 reserved.
// - IPv6 packet without extension options reports type 5; driver remaps.
// - Mask bit zero blocks its request bit from setting.
// - Reading requests clears mask bits whose request bit was set.
// - Writing one to a request bit clears its mask bit.
// - Writing one sets a mask bit; zero leaves it.
// - Request bit sets on posted packet with expired timer; write one clears.
module vlan_filter_and_rx_hash_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire vlan_hash_pkg::apb_req_type apb_req,
    output vlan_hash_pkg::apb_rsp_type apb_rsp,
    input wire vlan_hash_pkg::lookup_req_type lookup_req,
    output vlan_hash_pkg::lookup_rsp_type lookup_rsp,
    input wire logic packet_checksum_disable,
    input wire vlan_hash_pkg::rx_event_type rx_event,
    input wire vlan_hash_pkg::hash_class_type hash_class,
    output vlan_hash_pkg::steer_type steer,
    output logic irq
);
    import vlan_hash_pkg::*;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACCESS = 2'b10
    } bus_state_type;

    function automatic logic [6:0] addr_row(input logic [15:0] addr);
        logic [15:0] offset;
        offset = addr - VLAN_FILTER_BASE;
        return offset[ROW_WIDTH + ADDR_ROW_LSB - 1:ADDR_ROW_LSB];
    endfunction : addr_row

    function automatic logic is_filter_addr(input logic [15:0] addr);
        return addr >= VLAN_FILTER_BASE && addr <= VLAN_FILTER_LAST
            && addr[1:0] == 2'h0;
    endfunction : is_filter_addr

    bus_state_type bus_state;
    logic [1:0] queue_mode;
    logic hash_int_enable;
    logic [4:0] field_enable;
    logic [31:0] hash_interrupt_mask;
    logic [31:0] hash_interrupt_request;
    logic [2:0] event_status;
    logic [2:0] event_mask;
    logic filter_enable;
    logic [31:0] multi_queue_command;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [31:0] bus_word;
    logic [31:0] look_word;
    logic lookup_bit;
    logic setup;
    logic access;
    logic wr_fire;
    logic rd_fire;
    logic [31:0] request_sets;
    logic [2:0] event_sets;

    assign setup = apb_req.psel && !apb_req.penable && bus_state == BUS_IDLE;
    assign access = apb_req.psel && apb_req.penable && bus_state == BUS_ACCESS;
    // A refused access has no write effect and no read side effect.
    assign wr_fire = access && apb_req.pwrite && !apb_rsp.pslverr;
    assign rd_fire = access && !apb_req.pwrite && !apb_rsp.pslverr;

    assign multi_queue_command = {
        11'h000, field_enable, 13'h0000, hash_int_enable, queue_mode
    };

    filter_word_array filter_words (
        .clk(clk),
        .wr_en(wr_fire && is_filter_addr(apb_req.paddr)),
        .wr_row(addr_row(apb_req.paddr)),
        .wr_data(apb_req.pwdata),
        .bus_row(addr_row(apb_req.paddr)),
        .bus_data(bus_word),
        .look_row(lookup_req.vlan_id[ROW_MSB:ROW_LSB]),
        .look_data(look_word)
    );

    assign lookup_bit = look_word[lookup_req.vlan_id[COL_MSB:0]];

    // Requests may only set where the mask allows it.
    assign request_sets = rx_event.posted & rx_event.timer_expired
        & hash_interrupt_mask;

    always_comb
    begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (is_filter_addr(apb_req.paddr))
        begin
            next_prdata = bus_word;
        end
        else if (apb_req.paddr == MULTI_QUEUE_COMMAND_ADDR)
        begin
            next_prdata = multi_queue_command;
        end
        else if (apb_req.paddr == HASH_INTERRUPT_MASK_ADDR)
        begin
            next_prdata = hash_interrupt_mask;
        end
        else if (apb_req.paddr == HASH_INTERRUPT_REQUEST_ADDR)
        begin
            next_prdata = hash_interrupt_request;
        end
        else if (apb_req.paddr == EVENT_STATUS_ADDR)
        begin
            next_prdata = {29'h0000_0000, event_status};
        end
        else if (apb_req.paddr == EVENT_MASK_ADDR)
        begin
            next_prdata = {29'h0000_0000, event_mask};
        end
        else if (apb_req.paddr == FILTER_CONTROL_ADDR)
        begin
            next_prdata = {31'h0000_0000, filter_enable};
        end
        else
        begin
            next_pslverr = 1'b1;
        end
    end

    // Read data is sampled in the setup cycle, so the request word that
    // software sees is exactly the one whose bits clear the mask later.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bus_state <= BUS_IDLE;
            apb_rsp <= '0;
        end
        else if (setup)
        begin
            bus_state <= BUS_ACCESS;
            apb_rsp.pready <= 1'b1;
            apb_rsp.prdata <= next_prdata;
            apb_rsp.pslverr <= next_pslverr;
        end
        else if (access)
        begin
            bus_state <= BUS_IDLE;
            apb_rsp <= '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            queue_mode <= MULTI_QUEUE_COMMAND_RESET[1:0];
            hash_int_enable <= MULTI_QUEUE_COMMAND_RESET[HASH_INT_ENABLE_BIT];
            field_enable <= MULTI_QUEUE_COMMAND_RESET[20:16];
            filter_enable <= FILTER_CONTROL_RESET;
            event_mask <= EVENT_RESET;
        end
        else if (wr_fire)
        begin
            if (apb_req.paddr == MULTI_QUEUE_COMMAND_ADDR)
            begin
                queue_mode <= apb_req.pwdata[QUEUE_ENABLE_LSB +: 2];
                hash_int_enable <= apb_req.pwdata[HASH_INT_ENABLE_BIT];
                field_enable <=
                    apb_req.pwdata[FIELD_ENABLE_LSB +: FIELD_ENABLE_WIDTH];
            end
            else if (apb_req.paddr == FILTER_CONTROL_ADDR)
            begin
                filter_enable <= apb_req.pwdata[FILTER_ENABLE_BIT];
            end
            else if (apb_req.paddr == EVENT_MASK_ADDR)
            begin
                event_mask <= apb_req.pwdata[EVENT_WIDTH - 1:0];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hash_interrupt_mask <= HASH_INTERRUPT_MASK_RESET;
        end
        else if (wr_fire && apb_req.paddr == HASH_INTERRUPT_MASK_ADDR)
        begin
            hash_interrupt_mask <= hash_interrupt_mask | apb_req.pwdata;
        end
        else if (wr_fire && apb_req.paddr == HASH_INTERRUPT_REQUEST_ADDR)
        begin
            hash_interrupt_mask <= hash_interrupt_mask & ~apb_req.pwdata;
        end
        else if (rd_fire && apb_req.paddr == HASH_INTERRUPT_REQUEST_ADDR)
        begin
            hash_interrupt_mask <= hash_interrupt_mask & ~apb_rsp.prdata;
        end
    end

    // A new request in the cycle of a clearing write survives it.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hash_interrupt_request <= HASH_INTERRUPT_REQUEST_RESET;
        end
        else if (wr_fire && apb_req.paddr == HASH_INTERRUPT_REQUEST_ADDR)
        begin
            hash_interrupt_request <= (hash_interrupt_request
                & ~apb_req.pwdata) | request_sets;
        end
        else
        begin
            hash_interrupt_request <= hash_interrupt_request | request_sets;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lookup_rsp <= '0;
        end
        else
        begin
            lookup_rsp.done <= lookup_req.valid;
            lookup_rsp.pass <= lookup_req.valid
                && (!filter_enable || lookup_bit);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            steer <= '0;
        end
        else
        begin
            steer.queue_steering_enable <= queue_mode == QUEUE_MODE_HASH
                && packet_checksum_disable;
            steer.field_enable <= field_enable;
            if (hash_int_enable)
            begin
                steer.rx_int_pulse <= |(request_sets
                    & ~hash_interrupt_request);
            end
            else
            begin
                steer.rx_int_pulse <= rx_event.rx_packet;
            end
            steer.hash_type_valid <= hash_class.valid && hash_class.is_ipv6;
            // Without the extension options the packet reads as plain IPv6.
            if (hash_class.has_ext_option && field_enable[FIELD_IPV6EX])
            begin
                steer.hash_type <= HASH_TYPE_IPV6EX;
            end
            else if (field_enable[FIELD_IPV6])
            begin
                steer.hash_type <= HASH_TYPE_IPV6;
            end
            else
            begin
                steer.hash_type <= HASH_TYPE_NONE;
            end
        end
    end

    assign event_sets = {
        access && apb_rsp.pslverr,
        steer.rx_int_pulse,
        lookup_rsp.done && !lookup_rsp.pass
    };

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            event_status <= EVENT_RESET;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_fire && apb_req.paddr == EVENT_STATUS_ADDR)
            begin
                event_status <= (event_status
                    & ~apb_req.pwdata[EVENT_WIDTH - 1:0]) | event_sets;
            end
            else
            begin
                event_status <= event_status | event_sets;
            end
            irq <= |(event_status & event_mask);
        end
    end

    property p_lookup_row_bit;
        @(posedge clk) disable iff (rst)
        lookup_req.valid |=> lookup_rsp.done
            && lookup_rsp.pass == (!$past(filter_enable)
                || $past(lookup_bit));
    endproperty
    a_lookup_row_bit: assert property (p_lookup_row_bit)
        else $error("lookup answer does not match the selected bit");

    property p_filter_drop;
        @(posedge clk) disable iff (rst)
        lookup_req.valid && filter_enable && !lookup_bit
            |=> !lookup_rsp.pass ##1 event_status[EVENT_VLAN_DROP];
    endproperty
    a_filter_drop: assert property (p_filter_drop)
        else $error("tag with clear filter bit was not dropped");

    property p_queue_mode;
        @(posedge clk) disable iff (rst)
        ##1 steer.queue_steering_enable == ($past(queue_mode)
            == QUEUE_MODE_HASH && $past(packet_checksum_disable));
    endproperty
    a_queue_mode: assert property (p_queue_mode)
        else $error("queue steering enable wrong for queue mode");

    property p_mask_gates;
        @(posedge clk) disable iff (rst)
        ##1 ((hash_interrupt_request & ~$past(hash_interrupt_request))
            & ~$past(hash_interrupt_mask)) == 32'h0000_0000;
    endproperty
    a_mask_gates: assert property (p_mask_gates)
        else $error("masked request bit became set");

    property p_read_clears_mask;
        @(posedge clk) disable iff (rst)
        rd_fire && apb_req.paddr == HASH_INTERRUPT_REQUEST_ADDR
            |=> (hash_interrupt_mask & $past(apb_rsp.prdata)) == 32'h0;
    endproperty
    a_read_clears_mask: assert property (p_read_clears_mask)
        else $error("request read left a mask bit set");

    property p_write_clears_mask;
        @(posedge clk) disable iff (rst)
        wr_fire && apb_req.paddr == HASH_INTERRUPT_REQUEST_ADDR
            |=> (hash_interrupt_mask & $past(apb_req.pwdata)) == 32'h0;
    endproperty
    a_write_clears_mask: assert property (p_write_clears_mask)
        else $error("request write left a mask bit set");

    property p_mask_set_only;
        @(posedge clk) disable iff (rst)
        wr_fire && apb_req.paddr == HASH_INTERRUPT_MASK_ADDR
            |=> hash_interrupt_mask == ($past(hash_interrupt_mask)
                | $past(apb_req.pwdata));
    endproperty
    a_mask_set_only: assert property (p_mask_set_only)
        else $error("mask write did not only set bits");

    property p_request_sets;
        @(posedge clk) disable iff (rst)
        |request_sets |=> (hash_interrupt_request & $past(request_sets))
            == $past(request_sets);
    endproperty
    a_request_sets: assert property (p_request_sets)
        else $error("allowed request event was lost");

    property p_plain_interrupt;
        @(posedge clk) disable iff (rst)
        !hash_int_enable && rx_event.rx_packet |=> steer.rx_int_pulse
            ##1 event_status[EVENT_RX_INTERRUPT];
    endproperty
    a_plain_interrupt: assert property (p_plain_interrupt)
        else $error("packet gave no interrupt indication");

    property p_ipv6_type;
        @(posedge clk) disable iff (rst)
        hash_class.valid && hash_class.is_ipv6 && !hash_class.has_ext_option
            && field_enable[FIELD_IPV6]
            |=> steer.hash_type_valid && steer.hash_type == HASH_TYPE_IPV6;
    endproperty
    a_ipv6_type: assert property (p_ipv6_type)
        else $error("plain IPv6 packet not reported as type five");

    property p_apb_zero_wait;
        @(posedge clk) disable iff (rst)
        setup |=> apb_rsp.pready ##1 !apb_rsp.pready;
    endproperty
    a_apb_zero_wait: assert property (p_apb_zero_wait)
        else $error("access phase was not answered in one cycle");

endmodule : vlan_filter_and_rx_hash_ctrl

// file: tb/vlan_filter_and_rx_hash_ctrl_tb_top.sv
// Self-checking testbench for the VLAN filter and receive hash block.
module vlan_filter_and_rx_hash_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import vlan_hash_pkg::*;

    logic clk;
    logic rst;
    logic pcsd;
    logic irq;
    apb_req_type req;
    apb_rsp_type rsp;
    lookup_req_type lreq;
    lookup_rsp_type lrsp;
    rx_event_type rxe;
    hash_class_type hcl;
    steer_type steer;
    int mismatches;
    int num_checks;
    int cycles;
    logic [31:0] rdat;
    logic rerr;

    vlan_filter_and_rx_hash_ctrl DUT (
        .clk(clk),
        .rst(rst),
        .apb_req(req),
        .apb_rsp(rsp),
        .lookup_req(lreq),
        .lookup_rsp(lrsp),
        .packet_checksum_disable(pcsd),
        .rx_event(rxe),
        .hash_class(hcl),
        .steer(steer),
        .irq(irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    // The whole run needs about two hundred cycles; this ceiling cuts a hang.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One APB transfer; only the bench timeout bounds the wait for pready.
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge clk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (rsp.pready !== 1'b1);
        rdat = rsp.prdata;
        rerr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input string name, input logic [15:0] a,
                       input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(name, rdat, exp);
        check("read error flag", rerr, 32'h0000_0000);
    endtask : rdc

    task automatic look(input logic [11:0] id, input logic exp);
        @(posedge clk);
        lreq.valid <= 1'b1;
        lreq.vlan_id <= id;
        @(posedge clk);
        lreq.valid <= 1'b0;
        @(posedge clk);
        check("lookup done", lrsp.done, 32'h0000_0001);
        check("lookup pass", lrsp.pass, exp);
    endtask : look

    task automatic cls(input logic ext, input logic [3:0] exp);
        @(posedge clk);
        hcl <= '{valid: 1'b1, is_ipv6: 1'b1, has_ext_option: ext};
        @(posedge clk);
        hcl <= '0;
        @(posedge clk);
        check("hash type valid", steer.hash_type_valid, 32'h0000_0001);
        check("hash type", steer.hash_type, exp);
    endtask : cls

    // Counts receive interrupt pulses over the few cycles after an event.
    task automatic rxp(input logic [31:0] m, input logic p, input int exp);
        int n;
        n = 0;
        @(posedge clk);
        rxe <= '{rx_packet: p, posted: m, timer_expired: m};
        @(posedge clk);
        rxe <= '0;
        repeat (4)
        begin
            @(posedge clk);
            if (steer.rx_int_pulse === 1'b1)
                n++;
        end
        check("rx pulses", 32'(n), 32'(exp));
    endtask : rxp

    task automatic t_reset();
        check("steer at reset", 32'(steer), 32'h0000_0000);
        check("irq at reset", irq, 32'h0000_0000);
        rdc("command", MULTI_QUEUE_COMMAND_ADDR, 32'h0000_0000);
        rdc("mask", HASH_INTERRUPT_MASK_ADDR, 32'h0000_0000);
        rdc("request", HASH_INTERRUPT_REQUEST_ADDR, 32'h0000_0000);
        rdc("event status", EVENT_STATUS_ADDR, 32'h0000_0000);
    endtask : t_reset

    task automatic t_filter();
        wr(VLAN_FILTER_BASE + 16'h0178, 32'h0000_0200);
        wr(VLAN_FILTER_LAST, 32'h8000_0001);
        rdc("row 94", VLAN_FILTER_BASE + 16'h0178, 32'h0000_0200);
        rdc("row 127", VLAN_FILTER_LAST, 32'h8000_0001);
        look(12'hBC8, 1'b1);
        wr(FILTER_CONTROL_ADDR, 32'h0000_0001);
        look(12'hBC9, 1'b1);
        look(12'hBC8, 1'b0);
        look(12'hFFF, 1'b1);
        look(12'hFE0, 1'b1);
        look(12'hFE1, 1'b0);
        rdc("drop event", EVENT_STATUS_ADDR, 32'h0000_0001);
        wr(EVENT_STATUS_ADDR, 32'h0000_0001);
        rdc("drop cleared", EVENT_STATUS_ADDR, 32'h0000_0000);
    endtask : t_filter

    task automatic t_command();
        pcsd <= 1'b1;
        wr(MULTI_QUEUE_COMMAND_ADDR, 32'hFFFF_FFFF);
        rdc("command", MULTI_QUEUE_COMMAND_ADDR, 32'h001F_0007);
        check("fields", steer.field_enable, 32'h0000_001F);
        for (int m = 0; m < 4; m++)
        begin
            wr(MULTI_QUEUE_COMMAND_ADDR, 32'(m));
            repeat (2) @(posedge clk);
            check("steering", steer.queue_steering_enable, 32'(m == 1));
        end
        wr(MULTI_QUEUE_COMMAND_ADDR, 32'h0000_0001);
        pcsd <= 1'b0;
        repeat (2) @(posedge clk);
        check("no checksum off", steer.queue_steering_enable, 32'h0);
    endtask : t_command

    // Hashing is dropped by writing the command to zero, then a controller reset; the array survives it.
    task automatic t_restart();
        wr(MULTI_QUEUE_COMMAND_ADDR, 32'h0000_0000);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check("steer after reset", 32'(steer), 32'h0000_0000);
        rdc("command", MULTI_QUEUE_COMMAND_ADDR, 32'h0000_0000);
        rdc("row 94 kept", VLAN_FILTER_BASE + 16'h0178, 32'h0000_0200);
        look(12'hFE1, 1'b1);
    endtask : t_restart

    task automatic t_hash();
        pcsd <= 1'b1;
        wr(MULTI_QUEUE_COMMAND_ADDR, 32'h0018_0001);
        cls(1'b1, HASH_TYPE_IPV6EX);
        cls(1'b0, HASH_TYPE_IPV6);
        wr(MULTI_QUEUE_COMMAND_ADDR, 32'h0010_0001);
        cls(1'b1, HASH_TYPE_IPV6);
    endtask : t_hash

    task automatic t_mask();
        wr(MULTI_QUEUE_COMMAND_ADDR, 32'h0000_0005);
        wr(HASH_INTERRUPT_MASK_ADDR, 32'h0000_0005);
        wr(HASH_INTERRUPT_MASK_ADDR, 32'h0000_0000);
        rdc("mask set", HASH_INTERRUPT_MASK_ADDR, 32'h0000_0005);
        rxp(32'h0000_0003, 1'b0, 1);
        rxp(32'h0000_0000, 1'b1, 0);
        rdc("request", HASH_INTERRUPT_REQUEST_ADDR, 32'h0000_0001);
        rdc("mask read", HASH_INTERRUPT_MASK_ADDR, 32'h0000_0004);
        wr(HASH_INTERRUPT_REQUEST_ADDR, 32'h0000_0004);
        rdc("mask write", HASH_INTERRUPT_MASK_ADDR, 32'h0000_0000);
        rdc("request kept", HASH_INTERRUPT_REQUEST_ADDR, 32'h1);
        wr(HASH_INTERRUPT_REQUEST_ADDR, 32'h0000_0001);
        rdc("request w1c", HASH_INTERRUPT_REQUEST_ADDR, 32'h0);
        wr(MULTI_QUEUE_COMMAND_ADDR, 32'h0000_0001);
        rxp(32'h0000_0000, 1'b1, 1);
    endtask : t_mask

    // Status is cleared first so earlier pulses do not leak into irq.
    task automatic t_irq();
        wr(EVENT_STATUS_ADDR, 32'h0000_0007);
        wr(EVENT_MASK_ADDR, 32'h0000_0002);
        rxp(32'h0000_0000, 1'b1, 1);
        check("irq on", irq, 32'h0000_0001);
        rdc("status", EVENT_STATUS_ADDR, 32'h0000_0002);
        wr(EVENT_STATUS_ADDR, 32'h0000_0002);
        repeat (2) @(posedge clk);
        check("irq off", irq, 32'h0000_0000);
        apb(1'b0, 16'h5880, 32'h0000_0000);
        check("unmapped error", rerr, 32'h0000_0001);
        check("unmapped data", rdat, 32'h0000_0000);
        rdc("bus error event", EVENT_STATUS_ADDR, 32'h0000_0004);
        check("irq masked", irq, 32'h0000_0000);
    endtask : t_irq

    initial
    begin
        rst = 1'b1;
        pcsd = 1'b0;
        req = '0;
        lreq = '0;
        rxe = '0;
        hcl = '0;
        mismatches = 0;
        num_checks = 0;
        cycles = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_filter();
        t_command();
        t_restart();
        t_hash();
        t_mask();
        t_irq();
        print_verdict();
    end

endmodule : vlan_filter_and_rx_hash_ctrl_tb_top
